// [rtl/odl_defs.svh]
`ifndef ODL_DEFS_SVH
`define ODL_DEFS_SVH

// output image byte offsets
`define ODL_IMG_BYTE0 1'h0
`define ODL_IMG_BYTE1 1'h1
// diagnostic record
`define ODL_REC_ID 8'h01
`define ODL_REC_LEN 5'h14
`define ODL_IDX_SUMMARY 5'h00
`define ODL_IDX_MODCLASS 5'h01
`define ODL_IDX_CHTYPE 5'h04
`define ODL_IDX_NBITS 5'h05
`define ODL_IDX_NCH 5'h06
`define ODL_IDX_TS0 5'h10
`define ODL_IDX_TS1 5'h11
`define ODL_IDX_TS2 5'h12
`define ODL_IDX_TS3 5'h13
// byte values
`define ODL_MODCLASS_VAL 8'h0F
`define ODL_CHTYPE_VAL 8'h72
`define ODL_NBITS_VAL 8'h00
`define ODL_NCH_VAL 8'h00
`define ODL_ZERO_BYTE 8'h00
`define ODL_IMG_RESET 16'h0000
// summary bits 3, 5 and 6 never set
`define ODL_SUM_RSVD_MASK 8'h68
// summary bit positions
`define ODL_SUM_MODFAIL 0
`define ODL_SUM_INTERR 1
`define ODL_SUM_EXTERR 2
`define ODL_SUM_OVLD 4
`define ODL_SUM_PARERR 7
// microsecond tick: 1000 ns at 5 ns period
`define ODL_US_NS 1000
`define ODL_CLK_NS 5
`define ODL_US_CYC (`ODL_US_NS / `ODL_CLK_NS)
`define ODL_DIV_LAST 8'(`ODL_US_CYC - 1)

`endif

// [rtl/odl_pkg.sv]
package odl_pkg;
    typedef enum logic [2:0] {
        ODL_IDLE = 3'b001,
        ODL_INCOMING = 3'b010,
        ODL_OUTGOING = 3'b100
    } odl_alarm_t;
endpackage : odl_pkg

// [rtl/odl_output_diag.sv]
`timescale 1ns/1ps
`include "odl_defs.svh"

// What this block does
// - offset-zero byte writes drive outputs 0-7, offset-one byte writes drive 8-15
// - interrupt enabled: overload onset raises incoming diagnostic interrupt
// - red indicator follows overload regardless of interrupt setting
// - overload gone after an incoming interrupt: outgoing diagnostic interrupt raised automatically
// - incoming interrupt comes with a record describing its cause
// - controller reads record 01h; device answers it
// - record is 20 bytes, fixed field order, reserved bytes zero
// - summary byte: bits 0,1,2,4,7 flag errors; 3,5,6 clear
// - module class byte reads 0Fh
// - channel type byte reads 72h
// - diagnostic bits per channel byte reads 00h
// - channel count byte reads 00h
// - 32-bit microsecond counter from zero, wrapping
// - counter captured into timestamp at each diagnostic event
// - no input image bytes are produced
module odl_output_diag
    import odl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // output image write
    input wire logic imgWrite,
    input wire logic imgByteSel,
    input wire logic [7:0] imgWriteData,
    // parameter and fault sources
    input wire logic diagIntEnable,
    input wire logic [15:0] overloadIn,
    input wire logic moduleFail,
    input wire logic internalErr,
    input wire logic externalErr,
    input wire logic paramErr,
    // record read
    input wire logic recReadReq,
    input wire logic [7:0] recId,
    input wire logic [4:0] recIndex,
    output logic recReadAck,
    output logic recReadErr,
    output logic [7:0] recReadData,
    // interrupts and indication
    output logic diagIncoming,
    output logic diagOutgoing,
    output logic redLed,
    // process outputs
    output logic [15:0] outputProcessImage
);

    logic [15:0] image_reg, image_next;
    logic [7:0] div_reg, div_next;
    logic [31:0] usTick_reg, usTick_next;
    logic [31:0] stamp_reg, stamp_next;
    logic [7:0] summary_reg, summary_next;
    odl_alarm_t alarm_reg, alarm_next;
    logic inc_reg, inc_next, out_reg, out_next, led_reg, led_next;
    logic ack_reg, ack_next, err_reg, err_next;
    logic [7:0] rdata_reg, rdata_next;
    logic anyOvl, faultNow;

    function automatic logic [7:0] rec_byte(input logic [4:0] idx, input logic [7:0] sum,
                                           input logic [31:0] ts);
        unique case (idx)
            `ODL_IDX_SUMMARY: rec_byte = sum;
            `ODL_IDX_MODCLASS: rec_byte = `ODL_MODCLASS_VAL;
            `ODL_IDX_CHTYPE: rec_byte = `ODL_CHTYPE_VAL;
            `ODL_IDX_NBITS: rec_byte = `ODL_NBITS_VAL;
            `ODL_IDX_NCH: rec_byte = `ODL_NCH_VAL;
            `ODL_IDX_TS0: rec_byte = ts[7:0];
            `ODL_IDX_TS1: rec_byte = ts[15:8];
            `ODL_IDX_TS2: rec_byte = ts[23:16];
            `ODL_IDX_TS3: rec_byte = ts[31:24];
            default: rec_byte = `ODL_ZERO_BYTE;
        endcase
    endfunction : rec_byte

    // any single overloaded channel counts; no per-channel record is kept
    assign anyOvl = |overloadIn;
    assign faultNow = anyOvl | moduleFail | internalErr | externalErr | paramErr;

    always_comb
    begin
        image_next = image_reg;
        if (imgWrite)
        begin
            if (imgByteSel == `ODL_IMG_BYTE1)
                image_next[15:8] = imgWriteData;
            else
                image_next[7:0] = imgWriteData;
        end
        // microsecond divider and counter
        // wrap at the top is the plain carry-out of the 32-bit add
        div_next = (div_reg == `ODL_DIV_LAST) ? 8'h00 : div_reg + 8'h01;
        usTick_next = (div_reg == `ODL_DIV_LAST) ? usTick_reg + 32'h1 : usTick_reg;
        led_next = anyOvl;
        // summary reflects live causes; reserved bits stay clear
        summary_next = `ODL_ZERO_BYTE;
        summary_next[`ODL_SUM_MODFAIL] = moduleFail;
        summary_next[`ODL_SUM_INTERR] = internalErr;
        summary_next[`ODL_SUM_EXTERR] = externalErr;
        summary_next[`ODL_SUM_OVLD] = anyOvl;
        summary_next[`ODL_SUM_PARERR] = paramErr;
        stamp_next = stamp_reg;
        alarm_next = alarm_reg;
        inc_next = 1'b0;
        out_next = 1'b0;
        // one event at a time: more overload during incoming waits for outgoing
        unique case (alarm_reg)
            ODL_IDLE:
            begin
                if (diagIntEnable && anyOvl)
                begin
                    inc_next = 1'b1;
                    stamp_next = usTick_reg;
                    alarm_next = ODL_INCOMING;
                end
            end
            ODL_INCOMING:
            begin
                if (!anyOvl)
                begin
                    out_next = 1'b1;
                    stamp_next = usTick_reg;
                    alarm_next = ODL_IDLE;
                end
            end
            default:
                alarm_next = ODL_IDLE;
        endcase
        // reads have no side effects, so back-to-back requests are harmless
        // return data for record 01h only; any other record is acknowledged with recReadErr set
        ack_next = recReadReq;
        err_next = recReadReq && (recId != `ODL_REC_ID || recIndex >= `ODL_REC_LEN);
        rdata_next = rdata_reg;
        if (recReadReq)
            rdata_next = err_next ? `ODL_ZERO_BYTE : rec_byte(recIndex, summary_reg, stamp_reg);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            image_reg <= `ODL_IMG_RESET;
            div_reg <= 8'h00;
            usTick_reg <= 32'h0000_0000;
            stamp_reg <= 32'h0000_0000;
            summary_reg <= 8'h00;
            alarm_reg <= ODL_IDLE;
            inc_reg <= 1'b0;
            out_reg <= 1'b0;
            led_reg <= 1'b0;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            image_reg <= image_next;
            div_reg <= div_next;
            usTick_reg <= usTick_next;
            stamp_reg <= stamp_next;
            summary_reg <= summary_next;
            alarm_reg <= alarm_next;
            inc_reg <= inc_next;
            out_reg <= out_next;
            led_reg <= led_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // no input image port exists; all flows outward
    assign outputProcessImage = image_reg;
    assign redLed = led_reg;
    // record holds cause and stamp when incoming pulses
    assign diagIncoming = inc_reg;
    assign diagOutgoing = out_reg;
    assign recReadAck = ack_reg;
    assign recReadErr = err_reg;
    assign recReadData = rdata_reg;

    // registered outputs are checked one edge after their cause
    // high and low byte writes
    image_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        imgWrite && imgByteSel |=> outputProcessImage[15:8] == $past(imgWriteData))
        else $error("high byte not written");
    image_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        imgWrite && !imgByteSel |=> outputProcessImage[7:0] == $past(imgWriteData))
        else $error("low byte not written");

    led_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        ##1 redLed == $past(|overloadIn))
        else $error("red led not following overload");

    incoming_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
        alarm_reg == ODL_IDLE && diagIntEnable && |overloadIn |=> diagIncoming)
        else $error("incoming interrupt missing");
    incoming_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        !diagIntEnable && alarm_reg == ODL_IDLE |=> !diagIncoming)
        else $error("incoming interrupt while disabled");
    incoming_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        diagIncoming |=> !diagIncoming)
        else $error("incoming interrupt longer than one cycle");
    outgoing_raise_a: assert property (@(posedge mclk) disable iff (!rstn)
        alarm_reg == ODL_INCOMING && !(|overloadIn) |=> diagOutgoing && alarm_reg == ODL_IDLE)
        else $error("outgoing interrupt missing");
    outgoing_only_a: assert property (@(posedge mclk) disable iff (!rstn)
        diagOutgoing |-> $past(alarm_reg) == ODL_INCOMING)
        else $error("outgoing interrupt without incoming");
    alarm_legal_a: assert property (@(posedge mclk) disable iff (!rstn)
        $onehot(alarm_reg))
        else $error("alarm state code illegal");
    cause_record_a: assert property (@(posedge mclk) disable iff (!rstn)
        diagIncoming |-> summary_reg[`ODL_SUM_OVLD])
        else $error("incoming record lacks overload cause");

    stamp_capture_a: assert property (@(posedge mclk) disable iff (!rstn)
        diagIncoming |-> stamp_reg == $past(usTick_reg))
        else $error("timestamp not captured");
    stamp_outgoing_a: assert property (@(posedge mclk) disable iff (!rstn)
        diagOutgoing |-> stamp_reg == $past(usTick_reg))
        else $error("timestamp not captured at outgoing");
    tick_rate_a: assert property (@(posedge mclk) disable iff (!rstn)
        div_reg == `ODL_DIV_LAST |=> usTick_reg == $past(usTick_reg) + 32'h1)
        else $error("microsecond counter not stepping");
    tick_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        div_reg != `ODL_DIV_LAST |=> usTick_reg == $past(usTick_reg))
        else $error("microsecond counter stepping early");
    div_range_a: assert property (@(posedge mclk) disable iff (!rstn)
        div_reg <= `ODL_DIV_LAST)
        else $error("microsecond divider out of range");

    modclass_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recId == `ODL_REC_ID && recIndex == `ODL_IDX_MODCLASS
        |=> recReadAck && recReadData == `ODL_MODCLASS_VAL)
        else $error("module class byte wrong");
    chtype_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recId == `ODL_REC_ID && recIndex == `ODL_IDX_CHTYPE
        |=> recReadData == `ODL_CHTYPE_VAL)
        else $error("channel type byte wrong");
    nbits_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recId == `ODL_REC_ID && recIndex == `ODL_IDX_NBITS
        |=> recReadData == `ODL_NBITS_VAL)
        else $error("diagnostic bits byte wrong");
    nch_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recId == `ODL_REC_ID && recIndex == `ODL_IDX_NCH
        |=> recReadData == `ODL_NCH_VAL)
        else $error("channel count byte wrong");
    bad_record_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recId != `ODL_REC_ID |=> recReadErr && recReadData == `ODL_ZERO_BYTE)
        else $error("wrong record not refused");
    index_refuse_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq && recIndex >= `ODL_REC_LEN |=> recReadErr && recReadData == `ODL_ZERO_BYTE)
        else $error("index past record end not refused");
    read_ack_a: assert property (@(posedge mclk) disable iff (!rstn)
        recReadReq |=> recReadAck)
        else $error("record read not answered");
    ack_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
        !recReadReq |=> !recReadAck)
        else $error("record answer without request");

    summary_rsvd_a: assert property (@(posedge mclk) disable iff (!rstn)
        (summary_reg & `ODL_SUM_RSVD_MASK) == `ODL_ZERO_BYTE)
        else $error("reserved summary bits set");
    summary_live_a: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> (summary_reg != `ODL_ZERO_BYTE) == $past(faultNow))
        else $error("summary byte not tracking fault causes");

endmodule : odl_output_diag

// [dv/odl_ctrl_model.sv]
`timescale 1ns/1ps
module odl_ctrl_model (
    // clock
    input wire logic mclk,
    // image write
    output logic imgWrite,
    output logic imgByteSel,
    output logic [7:0] imgWriteData,
    // record read
    output logic recReadReq,
    output logic [7:0] recId,
    output logic [4:0] recIndex,
    input wire logic recReadAck,
    input wire logic recReadErr,
    input wire logic [7:0] recReadData
);
    initial {imgWrite, imgByteSel, imgWriteData, recReadReq, recId, recIndex} = '0;
    task write_byte(input logic sel, input logic [7:0] dat);
        @(posedge mclk);
        #1;
        {imgWrite, imgByteSel, imgWriteData} = {1'b1, sel, dat};
        @(posedge mclk);
        #1;
        imgWrite = 1'b0;
        // released data lines flip so a stale byte is never reused by mistake
        imgWriteData = ~dat;
    endtask : write_byte
    task read_byte(input logic [7:0] id, input logic [4:0] idx, output logic [7:0] dat,
        output logic err, output logic ok);
        ok = 1'b0;
        @(posedge mclk);
        #1;
        {recReadReq, recId, recIndex} = {1'b1, id, idx};
        @(posedge mclk);
        #1;
        {recReadReq, recId, recIndex} = {1'b0, ~id, ~idx};
        repeat (4)
        begin
            if (!ok && recReadAck === 1'b1)
            begin
                ok = 1'b1;
                dat = recReadData;
                err = recReadErr;
            end
            else if (!ok)
            begin
                @(posedge mclk);
                #1;
            end
        end
    endtask : read_byte
endmodule : odl_ctrl_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "odl_defs.svh"
`define ODL_CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin badCount++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
    logic mclk = 1'b0, rstn = 1'b0, diagIntEnable = 1'b0, e, ok;
    logic [3:0] faults = '0;
    logic [15:0] overloadIn = '0;
    logic imgWrite, imgByteSel, recReadReq, recReadAck, recReadErr;
    logic diagIncoming, diagOutgoing, redLed;
    logic [7:0] imgWriteData, recId, recReadData, d, expByte;
    logic [4:0] recIndex;
    logic [15:0] outputProcessImage;
    logic [31:0] ts;
    int badCount = 0, totalChecks = 0, cyc = 0, evCyc;
    int sumPos[4] = '{0, 1, 2, 7};
    always #2.5 mclk = ~mclk;
    // cycle count restarts with every reset, as the ticker does
    always @(posedge mclk or negedge rstn)
        if (!rstn) cyc <= 0;
        else cyc <= cyc + 1;
    odl_ctrl_model ctrl (.mclk(mclk), .imgWrite(imgWrite), .imgByteSel(imgByteSel),
        .imgWriteData(imgWriteData), .recReadReq(recReadReq), .recId(recId),
        .recIndex(recIndex), .recReadAck(recReadAck), .recReadErr(recReadErr),
        .recReadData(recReadData));
    odl_output_diag dut (.mclk(mclk), .rstn(rstn), .imgWrite(imgWrite),
        .imgByteSel(imgByteSel), .imgWriteData(imgWriteData), .diagIntEnable(diagIntEnable),
        .overloadIn(overloadIn), .moduleFail(faults[0]), .internalErr(faults[1]),
        .externalErr(faults[2]), .paramErr(faults[3]), .recReadReq(recReadReq),
        .recId(recId), .recIndex(recIndex), .recReadAck(recReadAck), .recReadErr(recReadErr),
        .recReadData(recReadData), .diagIncoming(diagIncoming), .diagOutgoing(diagOutgoing),
        .redLed(redLed), .outputProcessImage(outputProcessImage));
    task print_verdict;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task rd(input logic [7:0] id, input logic [4:0] idx);
        ctrl.read_byte(id, idx, d, e, ok);
        if (!ok)
        begin
            badCount++;
            print_verdict();
        end
    endtask : rd
    // timestamp equals whole microseconds counted before the event edge
    task chk_ts;
        for (int i = 0; i < 4; i++)
        begin
            rd(`ODL_REC_ID, `ODL_IDX_TS0 + 5'(i));
            ts[8*i +: 8] = d;
        end
        `ODL_CHK(ts, 32'(evCyc / `ODL_US_CYC))
    endtask : chk_ts
    task chk_reset;
        `ODL_CHK(outputProcessImage, 16'h0000)
        for (int i = 0; i < 20; i++)
        begin
            rd(`ODL_REC_ID, 5'(i));
            expByte = (i == 1) ? 8'h0F : (i == 4) ? 8'h72 : 8'h00;
            `ODL_CHK({e, d}, {1'b0, expByte})
        end
    endtask : chk_reset
    // reset in mid-run turns the outputs off again
    task chk_rerst;
        rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `ODL_CHK(outputProcessImage, 16'h0000)
        rstn = 1'b1;
        @(posedge mclk);
        #1;
        `ODL_CHK(outputProcessImage, 16'h0000)
    endtask : chk_rerst
    task chk_image;
        ctrl.write_byte(1'b0, 8'hA5);
        ctrl.write_byte(1'b1, 8'h3C);
        @(posedge mclk);
        #1;
        `ODL_CHK(outputProcessImage, 16'h3CA5)
        ctrl.write_byte(1'b1, 8'h00);
        @(posedge mclk);
        #1;
        `ODL_CHK(outputProcessImage, 16'h00A5)
    endtask : chk_image
    // each fault source except overload to its bit
    task chk_summary;
        for (int k = 0; k < 4; k++)
        begin
            faults = 4'(1 << k);
            rd(`ODL_REC_ID, `ODL_IDX_SUMMARY);
            `ODL_CHK(d, 8'(1 << sumPos[k]))
        end
        faults = '0;
    endtask : chk_summary
    // overload with interrupt off: lamp only
    task chk_quiet;
        ok = 1'b0;
        overloadIn = 16'h0100;
        repeat (3)
        begin
            @(posedge mclk);
            #1;
            ok = ok | diagIncoming;
        end
        `ODL_CHK(ok, 1'b0)
        `ODL_CHK(redLed, 1'b1)
        rd(`ODL_REC_ID, `ODL_IDX_SUMMARY);
        `ODL_CHK(d, 8'h10)
        overloadIn = '0;
        repeat (2) @(posedge mclk);
        #1;
        `ODL_CHK(redLed, 1'b0)
    endtask : chk_quiet
    task chk_event;
        diagIntEnable = 1'b1;
        repeat (450) @(posedge mclk);
        #1;
        overloadIn = 16'h8001;
        evCyc = cyc;
        @(posedge mclk);
        #1;
        `ODL_CHK({diagIncoming, redLed}, 2'b11)
        @(posedge mclk);
        #1;
        `ODL_CHK(diagIncoming, 1'b0)
        rd(`ODL_REC_ID, `ODL_IDX_SUMMARY);
        `ODL_CHK(d, 8'h10)
        chk_ts();
        repeat (600) @(posedge mclk);
        #1;
        overloadIn = '0;
        evCyc = cyc;
        @(posedge mclk);
        #1;
        `ODL_CHK({diagOutgoing, redLed}, 2'b10)
        chk_ts();
    endtask : chk_event
    // wrong record number and index past the end
    task chk_refuse;
        rd(8'h02, 5'h00);
        `ODL_CHK({e, d}, 9'h100)
        rd(`ODL_REC_ID, 5'h14);
        `ODL_CHK({e, d}, 9'h100)
    endtask : chk_refuse
    initial
    begin
        repeat (2) @(posedge mclk);
        #1;
        rstn = 1'b1;
        chk_reset();
        chk_image();
        chk_rerst();
        chk_summary();
        chk_quiet();
        chk_event();
        chk_refuse();
        print_verdict();
    end
endmodule : tb_top
